// ---- hw/dct_ddr_core.sv ----
// DDR device command decode, write burst capture and register slave
`timescale 1ns/1ns

// Function
// - A new WRITE truncates the running write burst, any bank.
// - Precharge cutting a burst of 4 makes the device ignore DQS.
// - Power-down with no open row is precharge type, else active type.
// - WRITE with A10 low leaves the row open after the burst.
// - Burst of 4 stores three further elements in programmed burst order.
module dct_ddr_core
    import dct_pkg::*;
#(
    parameter int COLW = 8
) (
    input wire logic mclk,                 // 250 MHz system clock
    input wire logic reset_n,              // Synchronous reset
    input wire dct_pins_t pins,            // DDR pins from controller
    input wire dct_av_req_t avReq,         // Avalon-MM request
    output logic [31:0] avReaddata,        // Avalon-MM read data
    output logic avWaitrequest,            // Avalon-MM wait request
    output dct_pwr_t pwrState,             // Current power state
    output logic [3:0] bankOpen            // Open row per bank
);
    localparam int PW = $bits(dct_pins_t);
    localparam int AW = COLW + 2;

    dct_pins_t pinLvl;
    logic ckPrev_q, dqsPrev_q, ckePrev_q;
    logic [31:0] ctrl_q;
    logic [AW-1:0] memAddrReg_q;
    logic [2:0] blCode_q;
    logic ilv_q;
    logic [3:0] bankOpen_q, bankOpen_d;
    dct_pwr_t pwr_q, pwr_d;
    logic wrActive_q, wrAuto_q;
    logic [1:0] wrBank_q;
    logic [COLW-1:0] wrCol_q;
    logic [2:0] wrIdx_q;
    logic avWait_q;
    logic [31:0] avRdata_q;
    logic [15:0] mem [0:(1<<AW)-1];

    dct_pin_sync #(.W(PW)) uSync (
        .mclk(mclk),
        .reset_n(reset_n),
        .pinIn(pins),
        .levelOut(pinLvl)
    );

    function automatic logic [COLW-1:0] burstCol(
        input logic [COLW-1:0] col, input logic [2:0] idx,
        input logic [2:0] bl, input logic ilv);
        logic [COLW-1:0] m;
        logic [COLW-1:0] ix;
        m = {{(COLW-3){1'b0}}, (bl == DCT_BL8) ? 3'h7 :
             (bl == DCT_BL2) ? 3'h1 : 3'h3};
        ix = {{(COLW-3){1'b0}}, idx};
        burstCol = (col & ~m) |
            (ilv ? ((col ^ ix) & m) : ((col + ix) & m));
    endfunction

    // Edge detection on filtered levels
    wire ckRise = pinLvl.ck && !ckPrev_q;
    wire dqsEdge = pinLvl.dqs ^ dqsPrev_q;
    wire ckeNow = pinLvl.cke;
    wire enable = ctrl_q[DCT_CTRL_EN_BIT];
    wire cmdValid = ckRise && enable && ckeNow && !pinLvl.cmd.csN;
    wire [2:0] cmdCode = {pinLvl.cmd.rasN, pinLvl.cmd.casN, pinLvl.cmd.weN};
    wire isAct = cmdValid && cmdCode == DCT_CMD_ACT;
    wire isWr = cmdValid && cmdCode == DCT_CMD_WR;
    wire isRd = cmdValid && cmdCode == DCT_CMD_RD;
    wire isPre = cmdValid && cmdCode == DCT_CMD_PRE;
    wire isMrs = cmdValid && cmdCode == DCT_CMD_MRS
        && pinLvl.cmd.ba == 2'h0;
    wire isRef = ckRise && enable && !pinLvl.cmd.csN
        && cmdCode == DCT_CMD_REF;
    wire a10 = pinLvl.cmd.addr[DCT_AP_BIT];
    wire [3:0] baOne = 4'h1 << pinLvl.cmd.ba;
    wire [3:0] blLen = (blCode_q == DCT_BL8) ? 4'h8 :
        (blCode_q == DCT_BL2) ? 4'h2 : 4'h4;
    wire wrLast = ({1'b0, wrIdx_q} + 4'h1) == blLen;
    wire memWe = wrActive_q && dqsEdge && pwr_q == PWR_ON;
    wire [COLW-1:0] memCol = burstCol(wrCol_q, wrIdx_q, blCode_q, ilv_q);
    wire [AW-1:0] memAddr = {wrBank_q, memCol};
    wire [15:0] memOld = mem[memAddr];
    wire [15:0] dmMask = {{8{pinLvl.dm[1]}}, {8{pinLvl.dm[0]}}};
    wire pdEntry = ckRise && ckePrev_q && !ckeNow;
    wire pdExit = ckRise && ckeNow && pwr_q != PWR_ON;

    // Bank state after this edge, auto precharge at burst end included
    always_comb begin
        bankOpen_d = bankOpen_q;
        if (memWe && wrLast && wrAuto_q)
            bankOpen_d = bankOpen_d & ~(4'h1 << wrBank_q);
        if (isAct)
            bankOpen_d = bankOpen_d | baOne;
        if (isPre)
            bankOpen_d = a10 ? 4'h0 : (bankOpen_d & ~baOne);
        // Read auto precharge closes the row at once; reads are not modelled
        if (isRd && a10)
            bankOpen_d = bankOpen_d & ~baOne;
    end

    // Power state chosen from the rows open at entry
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            PWR_ON: begin
                if (pdEntry && isRef)
                    pwr_d = PWR_SELF;
                else if (pdEntry)
                    pwr_d = (|bankOpen_d) ? PWR_ACT_DOWN : PWR_PRE_DOWN;
            end
            PWR_PRE_DOWN, PWR_ACT_DOWN, PWR_SELF: begin
                if (pdExit)
                    pwr_d = PWR_ON;
            end
            default: pwr_d = PWR_ON;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ckPrev_q <= 1'b0;
            dqsPrev_q <= 1'b0;
            ckePrev_q <= 1'b0;
            bankOpen_q <= 4'h0;
            pwr_q <= PWR_ON;
        end else begin
            ckPrev_q <= pinLvl.ck;
            dqsPrev_q <= pinLvl.dqs;
            if (ckRise)
                ckePrev_q <= ckeNow;
            bankOpen_q <= bankOpen_d;
            pwr_q <= pwr_d;
        end
    end

    // Write burst tracker; a WRITE, READ or PRECHARGE on the same edge overrides data
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wrActive_q <= 1'b0;
            wrAuto_q <= 1'b0;
            wrBank_q <= 2'h0;
            wrCol_q <= '0;
            wrIdx_q <= 3'h0;
            blCode_q <= DCT_BL_RESET;
            ilv_q <= 1'b0;
        end else begin
            if (memWe) begin
                wrIdx_q <= wrIdx_q + 3'h1;
                if (wrLast)
                    wrActive_q <= 1'b0;
            end
            if (isWr) begin
                wrActive_q <= 1'b1;
                // auto precharge only with A10 high
                wrAuto_q <= a10;
                wrBank_q <= pinLvl.cmd.ba;
                wrCol_q <= pinLvl.cmd.addr[COLW-1:0];
                wrIdx_q <= 3'h0;
            end else if (isPre || isRd) begin
                wrActive_q <= 1'b0;
            end
            if (isMrs) begin
                blCode_q <= pinLvl.cmd.addr[DCT_MR_BL_LSB +: 3];
                ilv_q <= pinLvl.cmd.addr[DCT_MR_ILV_BIT];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (memWe) begin
            if (!pinLvl.dm[0])
                mem[memAddr][7:0] <= pinLvl.dq[7:0];
            if (!pinLvl.dm[1])
                mem[memAddr][15:8] <= pinLvl.dq[15:8];
        end
    end

    // Avalon slave: one wait cycle, then answer for one cycle
    wire avReq1 = (avReq.read || avReq.write) && avWait_q;
    wire avWrHit = avReq.write && avWait_q;
    wire [31:0] statusWord = {21'h0, ilv_q, blCode_q, wrActive_q,
        pwr_q, bankOpen_q};
    wire [31:0] rdMux =
        (avReq.address == DCT_OFS_CTRL) ? ctrl_q :
        (avReq.address == DCT_OFS_STATUS) ? statusWord :
        (avReq.address == DCT_OFS_MEMADDR) ?
            {{(32-AW){1'b0}}, memAddrReg_q} :
        (avReq.address == DCT_OFS_MEMDATA) ?
            {16'h0, mem[memAddrReg_q]} : 32'h0;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            avWait_q <= 1'b1;
            avRdata_q <= 32'h0;
            ctrl_q <= DCT_CTRL_RESET;
            memAddrReg_q <= '0;
        end else begin
            avWait_q <= !avReq1;
            if (avReq1 && avReq.read)
                avRdata_q <= rdMux;
            if (avWrHit && avReq.address == DCT_OFS_CTRL)
                ctrl_q <= {31'h0, avReq.writedata[DCT_CTRL_EN_BIT]};
            if (avWrHit && avReq.address == DCT_OFS_MEMADDR)
                memAddrReg_q <= avReq.writedata[AW-1:0];
        end
    end

    assign avReaddata = avRdata_q;
    assign avWaitrequest = avWait_q;
    assign pwrState = pwr_q;
    assign bankOpen = bankOpen_q;

    sequence seqWrNoAp;
        isWr && !a10;
    endsequence

    AST_WRITE_TRUNCATES: assert property (@(posedge mclk)
        disable iff (!reset_n) isWr |=> wrActive_q && wrIdx_q == 3'h0)
        else $error("write did not restart burst");
    AST_PRE_STOPS_DQS: assert property (@(posedge mclk)
        disable iff (!reset_n) isPre && !isWr |=> !wrActive_q)
        else $error("burst still active after precharge");
    AST_PD_TYPE: assert property (@(posedge mclk)
        disable iff (!reset_n) pwr_q == PWR_ON && pdEntry && !isRef
        |=> pwr_q == (|bankOpen_q ? PWR_ACT_DOWN : PWR_PRE_DOWN))
        else $error("wrong power-down type");
    AST_NO_AP_OPEN: assert property (@(posedge mclk)
        disable iff (!reset_n) seqWrNoAp |=> !wrAuto_q)
        else $error("auto precharge set with A10 low");
    AST_BURST_END: assert property (@(posedge mclk)
        disable iff (!reset_n) memWe && wrLast && !cmdValid
        |=> !wrActive_q)
        else $error("burst ran past its length");
    AST_BURST_COUNT: assert property (@(posedge mclk)
        disable iff (!reset_n) memWe && !wrLast && !cmdValid
        |=> wrActive_q && wrIdx_q == $past(wrIdx_q) + 3'h1)
        else $error("burst index did not advance");
    AST_DM_MASK: assert property (@(posedge mclk)
        disable iff (!reset_n) memWe && (|pinLvl.dm)
        |=> ((mem[$past(memAddr)] ^ $past(memOld)) & $past(dmMask))
            == 16'h0)
        else $error("masked lanes were written");
    AST_AV_ANSWER: assert property (@(posedge mclk)
        disable iff (!reset_n) avReq1 |=> !avWait_q ##1 avWait_q)
        else $error("bus answer not one cycle");
endmodule

// ---- hw/dct_pkg.sv ----
// Shared constants and carrier types of the DDR command and write path
package dct_pkg;
    // Register byte offsets
    localparam logic [3:0] DCT_OFS_CTRL = 4'h0;
    localparam logic [3:0] DCT_OFS_STATUS = 4'h4;
    localparam logic [3:0] DCT_OFS_MEMADDR = 4'h8;
    localparam logic [3:0] DCT_OFS_MEMDATA = 4'hC;
    // Control field positions and reset value
    localparam int DCT_CTRL_EN_BIT = 0;
    localparam logic [31:0] DCT_CTRL_RESET = 32'h0000_0001;
    // Status field positions
    localparam int DCT_ST_BANK_LSB = 0;
    localparam int DCT_ST_PWR_LSB = 4;
    localparam int DCT_ST_WRACT_BIT = 6;
    localparam int DCT_ST_BL_LSB = 7;
    localparam int DCT_ST_ILV_BIT = 10;
    // Mode register fields and the auto precharge address bit
    localparam int DCT_MR_BL_LSB = 0;
    localparam int DCT_MR_ILV_BIT = 3;
    localparam int DCT_AP_BIT = 10;
    localparam logic [2:0] DCT_BL_RESET = 3'h2;
    localparam logic [2:0] DCT_BL2 = 3'h1;
    localparam logic [2:0] DCT_BL4 = 3'h2;
    localparam logic [2:0] DCT_BL8 = 3'h3;
    // Command codes: ras_n, cas_n, we_n
    localparam logic [2:0] DCT_CMD_MRS = 3'h0;
    localparam logic [2:0] DCT_CMD_REF = 3'h1;
    localparam logic [2:0] DCT_CMD_PRE = 3'h2;
    localparam logic [2:0] DCT_CMD_ACT = 3'h3;
    localparam logic [2:0] DCT_CMD_WR = 3'h4;
    localparam logic [2:0] DCT_CMD_RD = 3'h5;

    typedef enum logic [1:0] {
        PWR_ON, PWR_PRE_DOWN, PWR_ACT_DOWN, PWR_SELF
    } dct_pwr_t;

    typedef struct packed {
        logic csN;
        logic rasN;
        logic casN;
        logic weN;
        logic [1:0] ba;
        logic [12:0] addr;
    } dct_cmd_t;

    typedef struct packed {
        logic ck;
        logic cke;
        logic dqs;
        logic [1:0] dm;
        logic [15:0] dq;
        dct_cmd_t cmd;
    } dct_pins_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } dct_av_req_t;
endpackage

// ---- hw/dct_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module dct_pin_sync #(
    parameter int W = 8
) (
    input wire logic mclk,             // System clock
    input wire logic reset_n,          // Synchronous reset
    input wire logic [W-1:0] pinIn,    // Raw pins, foreign domain
    output logic [W-1:0] levelOut      // Filtered level
);
    logic [W-1:0] s1_q, s2_q, s3_q, level_q;
    wire [W-1:0] agree = ~(s2_q ^ s3_q);
    wire [W-1:0] level_d = (agree & s3_q) | (~agree & level_q);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level_q <= '0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign levelOut = level_q;
endmodule

// ---- tb/dct_ctrl_model.sv ----
// Memory controller model driving the DDR pins, one CK period a call
`timescale 1ns/1ns
module dct_ctrl_model
    import dct_pkg::*;
(
    input wire logic mclk, // System clock
    output dct_pins_t pins // Pins toward the device
);
    initial begin
        pins = '0;
        pins.cmd = '1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Sixteen mclk edges a call, so CK runs at 64 ns within a frame
    task automatic cyc(input logic [2:0] c, input logic [1:0] ba,
        input logic [12:0] a, input logic ke, input logic p,
        input logic [31:0] d, input logic [3:0] m);
        w(1);
        pins.cmd <= {1'b0, c, ba, a};
        pins.cke <= ke;
        pins.dq <= d[15:0];
        pins.dm <= m[1:0];
        w(4);
        pins.ck <= 1'b1;
        w(3);
        // DQS rise 3 mclk after CK rise
        pins.dqs <= p;
        w(3);
        pins.cmd <= '1;
        pins.dq <= d[31:16];
        pins.dm <= m[3:2];
        w(2);
        pins.ck <= 1'b0;
        w(2);
        pins.dqs <= 1'b0;
        w(1);
        // Released data lines show the inverse, never a stale value
        pins.dq <= ~d[31:16];
    endtask
endmodule

// ---- tb/test_ddr_sdram_command_timing.sv ----
// Self-checking bench of the DDR command decode and write path
`timescale 1ns/1ns
module test_ddr_sdram_command_timing
    import dct_pkg::*;
;
    typedef struct packed {
        logic [2:0] bl;
        logic ilv;
        logic [1:0] ba;
        logic [7:0] col;
        logic ap;
        logic [3:0] m;
        logic opn;
    } dct_row_t;
    logic mclk;
    logic resetN;
    dct_pins_t pins;
    dct_av_req_t avReq;
    logic [31:0] avReaddata;
    logic avWaitrequest;
    dct_pwr_t pwrState;
    logic [3:0] bankOpen;
    logic [15:0] expMem [int];
    logic [31:0] rd;
    logic [15:0] dv;
    logic [2:0] blc;
    logic il;
    int miscompares;
    int cmp_count;
    dct_row_t rows [6];

    dct_ddr_core dct_ddr_core_i (.mclk(mclk), .reset_n(resetN),
        .pins(pins), .avReq(avReq), .avReaddata(avReaddata),
        .avWaitrequest(avWaitrequest), .pwrState(pwrState),
        .bankOpen(bankOpen));
    dct_ctrl_model dct_ctrl_model_i (.mclk(mclk), .pins(pins));

    task automatic stop_test();
        $display("miscompares %0d compares %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
        input string s);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic av(input logic r, input logic [3:0] a,
        input logic [31:0] wd);
        avReq <= '{read: r, write: !r, address: a, writedata: wd};
        // Only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge mclk);
        end while (avWaitrequest !== 1'b0);
        rd = avReaddata;
        avReq <= '0;
        @(posedge mclk);
        chk({31'h0, avWaitrequest}, 32'h1, "bus answer length");
    endtask
    task automatic cmd(input logic [2:0] c, input logic [1:0] ba,
        input logic [12:0] a, input logic ke);
        dct_ctrl_model_i.cyc(c, ba, a, ke, 1'b0, 32'h0, 4'h0);
    endtask
    function automatic int blen();
        return (blc == DCT_BL2) ? 2 : (blc == DCT_BL8) ? 8 : 4;
    endfunction
    function automatic logic [7:0] colAt(input logic [7:0] c, input int k);
        int n;
        n = blen();
        return 8'((c & ~(n - 1)) | ((il ? (c ^ k) : (c + k)) & (n - 1)));
    endfunction
    // Scoreboard follows burst order and byte masks of each beat
    task automatic wrb(input logic [1:0] ba, input logic [7:0] c,
        input logic ap, input int np, input logic [3:0] m);
        logic [15:0] e;
        logic [3:0] mm;
        logic [9:0] key;
        for (int p = 0; p < np; p++) begin
            mm = (p == 0) ? m : 4'h0;
            dct_ctrl_model_i.cyc((p == 0) ? DCT_CMD_WR : 3'h7, ba,
                {2'h0, ap, 2'h0, c}, 1'b1, 1'b1, {dv + 16'h1, dv}, mm);
            for (int h = 0; h < 2; h++) begin
                key = {ba, colAt(c, 2 * p + h)};
                e = expMem.exists(key) ? expMem[key] : 16'h0;
                if (!mm[2 * h]) e[7:0] = dv[7:0] + 8'(h);
                if (!mm[2 * h + 1]) e[15:8] = dv[15:8];
                if (2 * p + h < blen()) expMem[key] = e;
            end
            dv = dv + 16'h2;
        end
    endtask
    task automatic chkMem(input logic [1:0] ba, input logic [7:0] c);
        av(1'b0, DCT_OFS_MEMADDR, {22'h0, ba, c});
        av(1'b1, DCT_OFS_MEMDATA, 32'h0);
        chk(rd, {16'h0, expMem[{ba, c}]}, "mem");
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #120000;
        miscompares++;
        stop_test();
    end
    initial begin
        resetN = 1'b0;
        avReq = '0;
        miscompares = 0;
        cmp_count = 0;
        dv = 16'hA000;
        rows[0] = '{DCT_BL4, 1'b0, 2'h0, 8'h00, 1'b0, 4'h0, 1'b1};
        rows[1] = '{DCT_BL4, 1'b0, 2'h1, 8'h22, 1'b0, 4'h0, 1'b1};
        rows[2] = '{DCT_BL8, 1'b1, 2'h2, 8'h15, 1'b1, 4'h0, 1'b0};
        rows[3] = '{DCT_BL2, 1'b0, 2'h3, 8'h41, 1'b1, 4'h0, 1'b0};
        rows[4] = '{DCT_BL4, 1'b1, 2'h0, 8'h03, 1'b0, 4'h6, 1'b1};
        rows[5] = '{DCT_BL8, 1'b0, 2'h1, 8'h3E, 1'b1, 4'h0, 1'b0};
        repeat (5) @(posedge mclk);
        resetN <= 1'b1;
        repeat (6) @(posedge mclk);
        cmd(DCT_CMD_PRE, 2'h0, 13'h400, 1'b1);
        cmd(DCT_CMD_MRS, 2'h0, {10'h0, DCT_BL4}, 1'b1);
        // idle period after the mode set
        cmd(3'h7, 2'h0, 13'h0, 1'b1);
        // refreshes between first mode set and second precharge all
        for (int k = 0; k < 2; k++) begin
            cmd(DCT_CMD_REF, 2'h0, 13'h0, 1'b1);
            // only NOPs while the refresh runs
            cmd(3'h7, 2'h0, 13'h0, 1'b1);
        end
        cmd(DCT_CMD_PRE, 2'h0, 13'h400, 1'b1);
        chk({30'h0, pwrState}, {30'h0, PWR_ON}, "auto refresh");
        foreach (rows[i]) begin
            cmd(DCT_CMD_MRS, 2'h0, {9'h0, rows[i].ilv, rows[i].bl}, 1'b1);
            blc = rows[i].bl;
            il = rows[i].ilv;
            // idle period after the mode set
            cmd(3'h7, 2'h0, 13'h0, 1'b1);
            av(1'b1, DCT_OFS_STATUS, 32'h0);
            chk({28'h0, rd[10:7]}, {28'h0, il, blc}, "mode");
            cmd(DCT_CMD_ACT, rows[i].ba, 13'h0, 1'b1);
            wrb(rows[i].ba, rows[i].col, rows[i].ap, blen() / 2, rows[i].m);
            cmd(3'h7, 2'h0, 13'h0, 1'b1);
            chk(32'(bankOpen[rows[i].ba]), 32'(rows[i].opn), "row");
            for (int k = 0; k < blen(); k++) begin
                chkMem(rows[i].ba, colAt(rows[i].col, k));
            end
            // precharge all long after the activate
            cmd(DCT_CMD_PRE, 2'h0, 13'h400, 1'b1);
        end
        resetN <= 1'b0;
        repeat (6) @(posedge mclk);
        resetN <= 1'b1;
        blc = DCT_BL_RESET;
        il = 1'b0;
        av(1'b0, DCT_OFS_STATUS, 32'hFFFF);
        av(1'b1, DCT_OFS_STATUS, 32'h0);
        chk(rd, {22'h0, DCT_BL_RESET, 7'h0}, "status reset");
        av(1'b1, 4'h2, 32'h0);
        chk(rd, 32'h0, "unmapped");
        av(1'b1, DCT_OFS_CTRL, 32'h0);
        chk(rd, DCT_CTRL_RESET, "ctrl reset");
        av(1'b0, DCT_OFS_CTRL, 32'h0);
        cmd(DCT_CMD_ACT, 2'h2, 13'h0, 1'b1);
        chk({28'h0, bankOpen}, 32'h0, "disabled");
        av(1'b0, DCT_OFS_CTRL, 32'h1);
        cmd(DCT_CMD_MRS, 2'h0, {10'h0, DCT_BL8}, 1'b1);
        blc = DCT_BL8;
        cmd(3'h7, 2'h0, 13'h0, 1'b1);
        cmd(DCT_CMD_ACT, 2'h0, 13'h0, 1'b1);
        cmd(DCT_CMD_ACT, 2'h2, 13'h0, 1'b1);
        wrb(2'h0, 8'h00, 1'b0, 1, 4'h0);
        wrb(2'h2, 8'h50, 1'b0, 4, 4'h0);
        for (int k = 0; k < 8; k++) begin
            chkMem(k[2] ? 2'h2 : 2'h0, k[2] ? 8'(8'h50 + k) : 8'(k));
        end
        cmd(DCT_CMD_MRS, 2'h0, {10'h0, DCT_BL4}, 1'b1);
        blc = DCT_BL4;
        cmd(3'h7, 2'h0, 13'h0, 1'b1);
        cmd(DCT_CMD_ACT, 2'h1, 13'h0, 1'b1);
        wrb(2'h1, 8'h20, 1'b0, 1, 4'h0);
        // write recovery before the cutting precharge
        cmd(3'h7, 2'h0, 13'h0, 1'b1);
        dct_ctrl_model_i.cyc(DCT_CMD_PRE, 2'h1, 13'h0, 1'b1, 1'b1,
            32'h5A5A5A5A, 4'h0);
        for (int k = 0; k < 4; k++) begin
            chkMem(2'h1, 8'(8'h20 + k));
        end
        chk({31'h0, bankOpen[1]}, 32'h0, "cut closes");
        // READ with auto precharge a full clock after ACTIVE
        cmd(DCT_CMD_ACT, 2'h1, 13'h0, 1'b1);
        cmd(3'h7, 2'h0, 13'h0, 1'b1);
        cmd(DCT_CMD_RD, 2'h1, 13'h400, 1'b1);
        chk({28'h0, bankOpen}, 32'h5, "read ap");
        wrb(2'h0, 8'h80, 1'b0, 1, 4'h0);
        // read to another bank a gap after the last pair
        cmd(3'h7, 2'h0, 13'h0, 1'b1);
        cmd(DCT_CMD_RD, 2'h2, 13'h0, 1'b1);
        av(1'b1, DCT_OFS_STATUS, 32'h0);
        chk({31'h0, rd[6]}, 32'h0, "read cuts");
        chk({28'h0, bankOpen}, 32'h5, "read no ap");
        cmd(DCT_CMD_PRE, 2'h0, 13'h400, 1'b1);
        cmd(DCT_CMD_ACT, 2'h3, 13'h0, 1'b1);
        // no burst runs at power-down entry
        cmd(3'h7, 2'h0, 13'h0, 1'b0);
        chk({30'h0, pwrState}, {30'h0, PWR_ACT_DOWN}, "act pd");
        cmd(3'h7, 2'h0, 13'h0, 1'b1);
        cmd(DCT_CMD_PRE, 2'h0, 13'h400, 1'b1);
        cmd(3'h7, 2'h0, 13'h0, 1'b0);
        chk({30'h0, pwrState}, {30'h0, PWR_PRE_DOWN}, "pre pd");
        cmd(3'h7, 2'h0, 13'h0, 1'b1);
        chk({30'h0, pwrState}, {30'h0, PWR_ON}, "pd exit");
        // all banks idle before self refresh
        cmd(DCT_CMD_REF, 2'h0, 13'h0, 1'b0);
        chk({30'h0, pwrState}, {30'h0, PWR_SELF}, "self");
        cmd(3'h7, 2'h0, 13'h0, 1'b1);
        chk({30'h0, pwrState}, {30'h0, PWR_ON}, "self exit");
        stop_test();
    end
endmodule
